// ===== design/ksd_pkg.sv
// Package: constants for the key source decoder and key latch flag
package ksd_pkg;
  // Core clock rate in kHz (40 MHz, 25 ns period)
  localparam int CLK_KHZ = 40_000;
  // Strobe window length in microseconds
  localparam int STROBE_US = 333;
  // Strobe repeat period in milliseconds
  localparam int PERIOD_MS = 10;
  // Least window length in cycles, rounded up
  localparam int STROBE_CYC = (STROBE_US * CLK_KHZ + 999) / 1000;
  // Repeat period in cycles
  localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;
  // Widths of the internal ports and the decoder
  localparam int PHASE_W = 2;
  localparam int SRC_W = 4;
  localparam int LINE_N = 16;
  localparam int RET_W = 4;
  // Reset values of the internal ports
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [3:0] SRC_RST = 4'h0;
  // Search phase codes
  localparam logic [1:0] PH_SINGLE = 2'h0;
  localparam logic [1:0] PH_EIGHTH = 2'h1;
  localparam logic [1:0] PH_QUARTER = 2'h2;
  localparam logic [1:0] PH_HALF = 2'h3;
  // Masks for one half, quarter and eighth of the lines
  localparam logic [15:0] MASK_HALF = 16'h00ff;
  localparam logic [15:0] MASK_QUARTER = 16'h000f;
  localparam logic [15:0] MASK_EIGHTH = 16'h0003;
  localparam logic [15:0] MASK_SINGLE = 16'h0001;
endpackage

// ===== design/ksd_tim_if.sv
// Interface: strobe timing from the period timer to the decoder core
`timescale 1ns/1ps
`default_nettype none
interface ksd_tim_if;
  // High during the strobe window of each period
  logic strobe_on;
  // One-cycle pulse at the first cycle of a window
  logic start;
  // One-cycle pulse when a full window has elapsed
  logic done;
  modport tim (output strobe_on, output start, output done);
  modport core (input strobe_on, input start, input done);
endinterface
`default_nettype wire

// ===== design/ksd_timer.sv
// Period timer: strobe window repeated once every period
`timescale 1ns/1ps
`default_nettype none
module ksd_timer
  import ksd_pkg::*;
#(
  parameter int PER_CYC = PERIOD_CYC,
  parameter int WIN_CYC = STROBE_CYC
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  ksd_tim_if.tim tim
);
  // Timer state
  typedef struct packed {
    logic [31:0] cnt;
    logic on;
    logic start;
    logic done;
  } ksd_tim_t;

  ksd_tim_t st;
  ksd_tim_t next_st;

  // Count through the period; window covers the first WIN_CYC cycles
  always_comb
  begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.done = 1'b0;
    if (st.cnt == 32'(PER_CYC - 1))
    begin
      // Wrap and open a new window
      next_st.cnt = 32'h0;
      next_st.start = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 32'h1;
    end
    next_st.on = (next_st.cnt < 32'(WIN_CYC));
    // Window has run its full length
    next_st.done = (st.cnt == 32'(WIN_CYC - 1));
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st <= '{cnt: 32'(PER_CYC - 1), on: 1'b0, start: 1'b0, done: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tim.strobe_on = st.on;
  assign tim.start = st.start;
  assign tim.done = st.done;

  // Done comes in the first cycle after the window, with the window already closed
  window_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.done |-> !st.on) else $error("window still open after done");
  // A window opens exactly with the start pulse
  window_open_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st.on) |-> st.start && st.cnt == 32'h0)
    else $error("window opened without start");
endmodule
`default_nettype wire

// ===== design/ksd_core.sv
// Key source decoder with key return latch and key latch status flag
//
// Function
// - Port write clears the latch flag
// - Either test instruction clears the flag unless the flag sets in that cycle
// - Flag sets after full window and capture
// - Test instructions report the flag
// - Flag works only with latch enable set
// - Power-on clear and clock stop zero flag
// - Undefined codes drive no source line
// - Strobe repeats once every period
// - Six-bit code decodes to sixteen lines
// - Strobes need latch and display enables
// - Return lines latched with strobe, readable
// - Phase upper bits read zero, not stored
`timescale 1ns/1ps
`default_nettype none
module ksd_core
  import ksd_pkg::*;
#(
  parameter int PER_CYC = PERIOD_CYC,
  parameter int WIN_CYC = STROBE_CYC
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic phase_wr,
  input wire logic [ksd_pkg::SRC_W-1:0] phase_wdata,
  input wire logic source_bit_wr,
  input wire logic [ksd_pkg::SRC_W-1:0] source_bit_wdata,
  input wire logic test_latch_true,
  input wire logic test_latch_false,
  input wire logic clock_stop_instr,
  input wire logic key_latch_enable,
  input wire logic display_enable,
  input wire logic [ksd_pkg::RET_W-1:0] key_return_input,
  output logic [ksd_pkg::LINE_N-1:0] key_source_line,
  output logic [ksd_pkg::RET_W-1:0] key_latch_read,
  output logic [ksd_pkg::SRC_W-1:0] phase_port,
  output logic [ksd_pkg::SRC_W-1:0] source_bit_port,
  output logic key_latch_flag,
  output logic test_skip
);
  import ksd_pkg::*;

  // Whole block state
  typedef struct packed {
    logic [PHASE_W-1:0] phase;     // Search phase
    logic [SRC_W-1:0] src;         // Source bit selection
    logic [RET_W-1:0] sync1;       // Pin synchroniser stages
    logic [RET_W-1:0] sync2;
    logic [RET_W-1:0] sync3;
    logic [RET_W-1:0] ret;         // Settled return level
    logic [RET_W-1:0] key_data;    // Latched key data
    logic [RET_W-1:0] rd;          // Read value
    logic flag;                    // Key latch status flag
    logic valid;                   // Current window fully enabled
    logic skip;                    // Result of last test instruction
    logic [LINE_N-1:0] lines;      // Driven source lines
  } ksd_core_t;

  ksd_core_t st;
  ksd_core_t next_st;
  ksd_tim_if tim_bus ();

  logic [LINE_N-1:0] dec_mask;     // Decoded lines for current code
  logic code_ok;                   // Code is one of the defined ones
  logic enabled;                   // Both enables set
  logic port_wr;                   // Any internal port write
  logic test_ev;                   // Any test instruction
  logic set_ev;                    // Flag set event

  // Period and window timing
  ksd_timer #(.PER_CYC(PER_CYC), .WIN_CYC(WIN_CYC)) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tim(tim_bus.tim)
  );

  // Binary search decoder on {phase, src}
  always_comb
  begin
    dec_mask = '0;
    code_ok = 1'b0;
    unique case (st.phase)
      PH_HALF:
      begin
        // Top source bit picks one half
        code_ok = (st.src[2:0] == 3'h0);
        dec_mask = MASK_HALF << {st.src[3], 3'h0};
      end
      PH_QUARTER:
      begin
        // Top two bits pick one quarter
        code_ok = (st.src[1:0] == 2'h0);
        dec_mask = MASK_QUARTER << {st.src[3:2], 2'h0};
      end
      PH_EIGHTH:
      begin
        // Top three bits pick one eighth
        code_ok = !st.src[0];
        dec_mask = MASK_EIGHTH << {st.src[3:1], 1'b0};
      end
      PH_SINGLE:
      begin
        // All four bits pick one line
        code_ok = 1'b1;
        dec_mask = MASK_SINGLE << st.src;
      end
    endcase
    if (!code_ok)
    begin
      dec_mask = '0;
    end
  end

  assign enabled = key_latch_enable && display_enable;
  assign port_wr = phase_wr || source_bit_wr;
  assign test_ev = test_latch_true || test_latch_false;
  // Set needs a whole enabled window with no new selection written
  assign set_ev = tim_bus.done && st.valid && key_latch_enable && !port_wr;

  // Next state
  always_comb
  begin
    next_st = st;
    // Internal ports; clock stop leaves them alone
    if (phase_wr)
    begin
      next_st.phase = phase_wdata[PHASE_W-1:0];
    end
    if (source_bit_wr)
    begin
      next_st.src = source_bit_wdata;
    end
    // Three-stage pin synchroniser, settles when stages two and three agree
    next_st.sync1 = key_return_input;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    if (st.sync2 == st.sync3)
    begin
      next_st.ret = st.sync3;
    end
    // Window validity tracking
    if (tim_bus.start)
    begin
      // A write taken with the start pulse makes the first strobe cycle stale
      next_st.valid = enabled && !port_wr;
    end
    else if (!enabled || port_wr)
    begin
      next_st.valid = 1'b0;
    end
    // Capture return lines at the end of the strobe
    if (tim_bus.done && st.valid)
    begin
      next_st.key_data = st.ret;
    end
    // Read path: latch when enabled, settled return level otherwise
    next_st.rd = key_latch_enable ? next_st.key_data : st.ret;
    // Test result reflects the flag before the clear
    if (test_latch_true)
    begin
      next_st.skip = st.flag;
    end
    else if (test_latch_false)
    begin
      next_st.skip = !st.flag;
    end
    // Flag: latch disable and clock stop clears win over set, set wins over test clears; a port write blocks the set
    if (!key_latch_enable || clock_stop_instr)
    begin
      next_st.flag = 1'b0;
    end
    else if (set_ev)
    begin
      next_st.flag = 1'b1;
    end
    else if (port_wr || test_ev)
    begin
      next_st.flag = 1'b0;
    end
    // Drive lines only inside the window with both enables
    next_st.lines = (tim_bus.strobe_on && enabled) ? dec_mask : '0;
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st <= '{phase: PHASE_RST, src: SRC_RST, flag: 1'b0, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign key_source_line = st.lines;
  assign key_latch_read = st.rd;
  assign phase_port = {2'h0, st.phase};
  assign source_bit_port = st.src;
  assign key_latch_flag = st.flag;
  assign test_skip = st.skip;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Sequence of a fully enabled window ending
  sequence window_done_s;
    tim_bus.done && st.valid && key_latch_enable && !port_wr && !clock_stop_instr;
  endsequence

  port_clear_a: assert property (port_wr |=> !st.flag)
    else $error("flag not cleared by port write");
  test_clear_a: assert property (test_ev && !set_ev |=> !st.flag)
    else $error("flag not cleared by test");
  flag_set_a: assert property (window_done_s |=>
    st.flag && st.key_data == $past(st.ret))
    else $error("flag or data not set at window end");
  test_report_a: assert property (test_latch_true |=> st.skip == $past(st.flag))
    else $error("test result wrong");
  // Inverted test reports the flag's complement
  test_false_a: assert property (test_latch_false && !test_latch_true |=>
    st.skip == !$past(st.flag))
    else $error("inverted test result wrong");
  latch_off_a: assert property (!key_latch_enable |=> !st.flag)
    else $error("flag active while latch disabled");
  clock_stop_a: assert property (clock_stop_instr && !port_wr |=>
    !st.flag && $stable(st.phase) && $stable(st.src))
    else $error("clock stop handling wrong");
  bad_code_a: assert property (!code_ok |=> st.lines == '0)
    else $error("lines driven for undefined code");
  enable_gate_a: assert property (!(enabled && tim_bus.strobe_on) |=>
    st.lines == '0)
    else $error("lines driven outside enabled window");
  one_hot_a: assert property (st.phase == PH_SINGLE &&
    tim_bus.strobe_on && enabled |=> $onehot(st.lines))
    else $error("single phase not one line");
endmodule
`default_nettype wire

// ===== sim/ksd_keys.sv
// Key matrix model: switches joining source lines to return lines
`timescale 1ns/1ps
`default_nettype none
module ksd_keys
  import ksd_pkg::*;
(
  input wire logic [ksd_pkg::LINE_N-1:0] key_source_line,
  input wire logic [63:0] press,
  output logic [ksd_pkg::RET_W-1:0] key_return_input
);
  // A closed switch passes its driven line; pull-downs keep open returns low
  always_comb
  begin
    key_return_input = '0;
    for (int i = 0; i < LINE_N; i++)
      if (key_source_line[i])
        key_return_input |= press[4*i +: 4];
  end
endmodule
`default_nettype wire

// ===== sim/ksd_core_tb.sv
// Testbench: key source decode, key latch flag, tests and clears
`timescale 1ns/1ps
`default_nettype none
module ksd_core_tb;
  import ksd_pkg::*;
  localparam int PER = 40; // Short repeat period
  localparam int WIN = 8; // Short strobe window
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic phase_wr = 1'b0;
  logic [3:0] phase_wdata = 4'h0;
  logic source_bit_wr = 1'b0;
  logic [3:0] source_bit_wdata = 4'h0;
  logic test_latch_true = 1'b0;
  logic test_latch_false = 1'b0;
  logic clock_stop_instr = 1'b0;
  logic key_latch_enable = 1'b1;
  logic display_enable = 1'b1;
  logic [3:0] key_return_input;
  logic [15:0] key_source_line;
  logic [3:0] key_latch_read;
  logic [3:0] phase_port;
  logic [3:0] source_bit_port;
  logic key_latch_flag;
  logic test_skip;
  logic [63:0] press = 64'h0; // Pressed switches, four per source line
  logic [15:0] acc; // Lines seen while waiting for a set
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int t0;

  ksd_core #(.PER_CYC(PER), .WIN_CYC(WIN)) ksd_core_inst (.core_clk, .sys_rst, .phase_wr,
    .phase_wdata, .source_bit_wr, .source_bit_wdata, .test_latch_true, .test_latch_false,
    .clock_stop_instr, .key_latch_enable, .display_enable, .key_return_input,
    .key_source_line, .key_latch_read, .phase_port, .source_bit_port, .key_latch_flag,
    .test_skip);
  ksd_keys ksd_keys_inst (.key_source_line, .press, .key_return_input);

  // Clock, 25 ns period
  always #12.5 core_clk = ~core_clk;

  // Expected lines for a phase and source code
  function automatic logic [15:0] dec(input logic [1:0] p, input logic [3:0] s);
    case (p)
      2'h3: dec = (s[2:0] == 3'h0) ? (s[3] ? 16'hff00 : 16'h00ff) : 16'h0000;
      2'h2: dec = (s[1:0] == 2'h0) ? 16'h000f << (4 * s[3:2]) : 16'h0000;
      2'h1: dec = s[0] ? 16'h0000 : 16'h0003 << (2 * s[3:1]);
      default: dec = 16'h0001 << s;
    endcase
  endfunction

  // Expected return data for a set of driven lines
  function automatic logic [3:0] ret(input logic [15:0] l);
    ret = 4'h0;
    for (int i = 0; i < 16; i++)
      if (l[i])
        ret |= press[4*i +: 4];
  endfunction

  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle pulse: 0 phase write, 1 source write, 2/3 tests, 4 clock stop
  task op(input int k, input logic [3:0] d);
    @(posedge core_clk);
    phase_wr <= (k == 0);
    source_bit_wr <= (k == 1);
    test_latch_true <= (k == 2);
    test_latch_false <= (k == 3);
    clock_stop_instr <= (k == 4);
    phase_wdata <= d;
    source_bit_wdata <= d;
    @(posedge core_clk);
    {phase_wr, source_bit_wr, test_latch_true, test_latch_false, clock_stop_instr} <= 5'h00;
    @(negedge core_clk);
  endtask

  // Wait a bounded time for the flag, gathering driven lines
  task wait_set(input logic exp);
    int n;
    acc = 16'h0000;
    n = 0;
    @(negedge core_clk);
    while (key_latch_flag !== 1'b1 && n < 3 * PER)
    begin
      @(negedge core_clk);
      acc |= key_source_line;
      n++;
    end
    chk(16'(key_latch_flag), 16'(exp));
  endtask

  // Counts, verdict, end of run
  task final_report;
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the three thousand or so cycles the run needs
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      $display("Error at %0t: run did not finish in time", $time);
      num_errors++;
      final_report;
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h7a996942));
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(16'({key_latch_flag, test_skip, key_latch_read, phase_port, source_bit_port}),
      16'h0);
    // Every code, random switches and random ignored phase bits
    for (int c = 0; c < 64; c++)
    begin
      press = {$urandom, $urandom};
      op(1, c[3:0]);
      op(0, {2'($urandom), c[5:4]});
      wait_set(1'b1);
      chk(acc, dec(c[5:4], c[3:0]));
      chk(16'(key_latch_read), 16'(ret(dec(c[5:4], c[3:0]))));
      chk(16'(phase_port), 16'({2'h0, c[5:4]}));
      chk(16'(source_bit_port), 16'(c[3:0]));
    end
    // Clearing tests, then spacing of sets
    t0 = cyc;
    op(2, 4'h0);
    chk(16'({test_skip, key_latch_flag}), 16'h2);
    wait_set(1'b1);
    chk(16'(cyc - t0), 16'(PER));
    op(3, 4'h0);
    chk(16'({test_skip, key_latch_flag}), 16'h0);
    op(3, 4'h0);
    chk(16'({test_skip, key_latch_flag}), 16'h2);
    // Port write and clock stop clear the flag, ports kept
    wait_set(1'b1);
    op(1, source_bit_port);
    chk(16'(key_latch_flag), 16'h0);
    op(0, 4'hf);
    chk(16'(phase_port), 16'h3);
    wait_set(1'b1);
    op(4, 4'h0);
    chk(16'({key_latch_flag, phase_port}), 16'h3);
    // Defined half selection, so that a missing gate would show lines
    op(1, 4'h0);
    wait_set(1'b1);
    chk(acc, dec(2'h3, 4'h0));
    // Latch enable low kills the flag, either enable low stops strobes
    @(posedge core_clk);
    key_latch_enable <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(16'(key_latch_flag), 16'h0);
    wait_set(1'b0);
    chk(acc, 16'h0);
    @(posedge core_clk);
    key_latch_enable <= 1'b1;
    display_enable <= 1'b0;
    wait_set(1'b0);
    chk(acc, 16'h0);
    // Reset in mid-run, then a fresh window on the reset selection
    @(posedge core_clk);
    display_enable <= 1'b1;
    wait_set(1'b1);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(16'({key_latch_flag, phase_port}), 16'h0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    wait_set(1'b1);
    chk(acc, dec(PHASE_RST, SRC_RST));
    final_report;
  end
endmodule
`default_nettype wire
